// >>> src/cie_entry.sv
`timescale 1ns/1ps
`default_nettype none
module cie_entry import cie_pkg::*; #(
	parameter int NSRC = 8,
	parameter int SELW = 3
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// peripheral sources
	input wire logic [NSRC-1:0] src_event,
	input wire logic [NSRC-1:0] src_enable,
	input wire logic [NSRC-1:0] src_flag_clr,
	output logic [NSRC-1:0] src_flag_q,
	// core: instruction boundary and mask control
	input wire logic instr_done,
	input wire logic soft_int_exec,
	input wire logic dbg_soft_req,
	input wire logic mask_set,
	input wire logic mask_clr,
	input wire logic cond_restore,
	input wire logic [7:0] cond_stacked,
	output logic global_mask_q,
	// core: registers to stack
	input wire logic [15:0] ret_pc,
	input wire logic [7:0] reg_a,
	input wire logic [7:0] reg_x,
	input wire logic [7:0] cond_byte,
	input wire logic [15:0] sp_in,
	output logic [15:0] sp_q,
	// memory access
	output logic mem_req_q,
	output logic mem_we_q,
	output logic [15:0] mem_addr_q,
	output logic [7:0] mem_wdata_q,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	// instruction queue and status
	output logic [7:0] queue_byte_q,
	output logic queue_valid_q,
	output logic [15:0] new_pc_q,
	output logic entry_busy_q,
	output logic entry_done_q
);
	logic [NSRC-1:0] src_req;
	logic qualified;
	logic start;
	logic dbg_pend_q;
	cie_state_t state_q;
	logic [2:0] push_cnt_q;
	logic [1:0] fill_cnt_q;
	logic [15:0] vec_q;
	logic [15:0] fetch_q;
	logic [7:0] stack_byte;
	logic seen_q;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] vec_of(input logic [NSRC-1:0] req, input logic [15:0] dflt);
		logic [15:0] v;
		v = dflt;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				v = SRC_VECTOR_TOP - 16'(2 * i);
			end
		end
		return v;
	endfunction

	cie_flags #(.NSRC(NSRC)) u_flags (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.src_event(src_event),
		.src_enable(src_enable),
		.src_flag_clr(src_flag_clr),
		.src_flag_q(src_flag_q),
		.src_req(src_req)
	);

	// ----------------------------------------------------------------
	// qualification and start
	// ----------------------------------------------------------------
	assign qualified = (src_req != '0) && !global_mask_q;
	// only an instruction boundary starts entry, never mid-instruction
	assign start = (state_q == CIE_IDLE) && instr_done
		&& (qualified || soft_int_exec || dbg_pend_q);

	// next byte to push, loaded at the ack so a pending write never sees its data change
	always_comb begin
		case (push_cnt_q)
			3'h0: stack_byte = ret_pc[15:8];
			3'h1: stack_byte = reg_x;
			3'h2: stack_byte = reg_a;
			default: stack_byte = cond_byte;
		endcase
	end

	// debug injection waits as a pending instruction-level interrupt
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			dbg_pend_q <= 1'b0;
		end else if (dbg_soft_req) begin
			dbg_pend_q <= 1'b1;
		end else if (start) begin
			dbg_pend_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// global mask
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			global_mask_q <= MASK_RESET;
		end else if (state_q == CIE_PUSH && mem_ack && push_cnt_q == PUSH_LAST) begin
			global_mask_q <= 1'b1;
		end else if (cond_restore) begin
			global_mask_q <= cond_stacked[COND_MASK_BIT];
		end else if (mask_clr) begin
			global_mask_q <= 1'b0;
		end else if (mask_set) begin
			global_mask_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// entry sequence, shared by hardware requests and the instruction
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= CIE_IDLE;
			push_cnt_q <= '0;
			fill_cnt_q <= '0;
			vec_q <= '0;
			fetch_q <= '0;
			sp_q <= '0;
			mem_req_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_addr_q <= '0;
			mem_wdata_q <= '0;
			queue_byte_q <= '0;
			queue_valid_q <= 1'b0;
			new_pc_q <= '0;
			entry_busy_q <= 1'b0;
			entry_done_q <= 1'b0;
		end else begin
			queue_valid_q <= 1'b0;
			entry_done_q <= 1'b0;
			case (state_q)
				CIE_IDLE: begin
					if (start) begin
						// one sequence for all causes; only the vector differs
						state_q <= CIE_PUSH;
						vec_q <= (soft_int_exec || dbg_pend_q) ? SOFT_VECTOR
							: vec_of(src_req, SOFT_VECTOR);
						push_cnt_q <= '0;
						sp_q <= sp_in;
						entry_busy_q <= 1'b1;
						mem_req_q <= 1'b1;
						mem_we_q <= 1'b1;
						mem_addr_q <= sp_in;
						mem_wdata_q <= ret_pc[7:0];
					end
				end
				CIE_PUSH: begin
					if (mem_ack) begin
						sp_q <= sp_q - 16'h0001;
						if (push_cnt_q == PUSH_LAST) begin
							// hardware vector chosen again after the push (not for soft or debug entry): latest highest priority wins
							state_q <= CIE_VEC_HI;
							mem_we_q <= 1'b0;
							if (vec_q != SOFT_VECTOR && src_req != '0) begin
								mem_addr_q <= vec_of(src_req, vec_q);
								vec_q <= vec_of(src_req, vec_q);
							end else begin
								mem_addr_q <= vec_q;
							end
						end else begin
							push_cnt_q <= push_cnt_q + 3'h1;
							mem_addr_q <= sp_q - 16'h0001;
							mem_wdata_q <= stack_byte;
						end
					end
				end
				CIE_VEC_HI: begin
					if (mem_ack) begin
						fetch_q[15:8] <= mem_rdata;
						mem_addr_q <= vec_q + 16'h0001;
						state_q <= CIE_VEC_LO;
					end
				end
				CIE_VEC_LO: begin
					if (mem_ack) begin
						fetch_q[7:0] <= mem_rdata;
						mem_addr_q <= {fetch_q[15:8], mem_rdata};
						fill_cnt_q <= '0;
						state_q <= CIE_FILL;
					end
				end
				default: begin
					if (mem_ack) begin
						queue_byte_q <= mem_rdata;
						queue_valid_q <= 1'b1;
						mem_addr_q <= mem_addr_q + 16'h0001;
						if (fill_cnt_q == FILL_LAST) begin
							// pc points past the three queued bytes
							new_pc_q <= mem_addr_q + 16'h0001;
							mem_req_q <= 1'b0;
							entry_busy_q <= 1'b0;
							entry_done_q <= 1'b1;
							state_q <= CIE_IDLE;
						end else begin
							fill_cnt_q <= fill_cnt_q + 2'h1;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			seen_q <= 1'b0;
		end else begin
			seen_q <= 1'b1;
		end
	end

	sequence s_push_done;
		state_q == CIE_PUSH && mem_ack && push_cnt_q == PUSH_LAST;
	endsequence
	sequence s_fill_byte;
		state_q == CIE_FILL && mem_ack;
	endsequence

	AST_RESET_MASK: assert property (@(posedge sys_clk) disable iff (!resetn)
		!seen_q |-> global_mask_q)
		else $error("mask not set after reset");
	AST_MASKED_NO_ENTRY: assert property (@(posedge sys_clk) disable iff (!resetn)
		start && !soft_int_exec && !dbg_pend_q |-> !global_mask_q && src_req != '0)
		else $error("masked request started entry");
	AST_BOUNDARY: assert property (@(posedge sys_clk) disable iff (!resetn)
		state_q == CIE_IDLE && !instr_done |=> state_q == CIE_IDLE)
		else $error("entry started off an instruction boundary");
	AST_PUSH_THEN_MASK: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_push_done |=> global_mask_q && state_q == CIE_VEC_HI && !mem_we_q)
		else $error("mask not set after register push");
	AST_PUSH_WRITES: assert property (@(posedge sys_clk) disable iff (!resetn)
		state_q == CIE_PUSH |-> mem_req_q && mem_we_q && mem_addr_q == sp_q)
		else $error("push not a stack write");
	AST_PUSH_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
		state_q == CIE_PUSH && !mem_ack |=> $stable(mem_wdata_q) && $stable(mem_addr_q))
		else $error("pending stack write changed");
	AST_FILL_THREE: assert property (@(posedge sys_clk) disable iff (!resetn)
		(s_fill_byte and (fill_cnt_q == FILL_LAST)) |=> queue_valid_q && entry_done_q
		&& state_q == CIE_IDLE)
		else $error("queue fill did not end after three bytes");
	AST_RESTORE: assert property (@(posedge sys_clk) disable iff (!resetn)
		cond_restore && state_q == CIE_IDLE
		|=> global_mask_q == $past(cond_stacked[COND_MASK_BIT]))
		else $error("mask not restored from stacked value");
	AST_DBG_PEND: assert property (@(posedge sys_clk) disable iff (!resetn)
		dbg_soft_req |=> dbg_pend_q)
		else $error("debug injection not held pending");
	AST_DBG_TAKEN: assert property (@(posedge sys_clk) disable iff (!resetn)
		dbg_pend_q && state_q == CIE_IDLE && instr_done |=> state_q == CIE_PUSH
		&& vec_q == SOFT_VECTOR)
		else $error("debug injection not entered");
	AST_NEST_CLEAR: assert property (@(posedge sys_clk) disable iff (!resetn)
		mask_clr && !cond_restore && !(state_q == CIE_PUSH && mem_ack
		&& push_cnt_q == PUSH_LAST) |=> !global_mask_q)
		else $error("mask clear refused");
endmodule
`default_nettype wire

// >>> src/cie_pkg.sv
// Contract
// - an event in an enabled source sets its read-only status flag
// - take a maskable request only when local enable is 1 and mask is 0
// - the global mask comes up set after any reset
// - a qualified request waits for the current instruction to finish
// - hardware entry uses the very same sequence as the software interrupt instruction
// - push the processor registers first, then set the global mask
// - fetch the highest-priority vector, then fill the queue with three bytes
// - restoring the stacked condition code register returns the mask to its stacked value
// - debug logic can inject a software interrupt taken through the normal entry
package cie_pkg;
	// ----------------------------------------------------------------
	// condition code register layout and sequence lengths
	// ----------------------------------------------------------------
	localparam int COND_MASK_BIT = 3;
	localparam logic MASK_RESET = 1'b1;
	localparam int PUSH_BYTES = 5;
	localparam int FILL_BYTES = 3;
	localparam logic [2:0] PUSH_LAST = 3'h4;
	localparam logic [1:0] FILL_LAST = 2'h2;
	// ----------------------------------------------------------------
	// vector map: two bytes per vector, lowest source index is top priority
	// ----------------------------------------------------------------
	localparam logic [15:0] SOFT_VECTOR = 16'hFFFC;
	localparam logic [15:0] SRC_VECTOR_TOP = 16'hFFFA;
	typedef enum logic [2:0] {
		CIE_IDLE,
		CIE_PUSH,
		CIE_VEC_HI,
		CIE_VEC_LO,
		CIE_FILL
	} cie_state_t;
endpackage

// >>> src/cie_flags.sv
`timescale 1ns/1ps
`default_nettype none
module cie_flags import cie_pkg::*; #(
	parameter int NSRC = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// peripheral side
	input wire logic [NSRC-1:0] src_event,
	input wire logic [NSRC-1:0] src_enable,
	input wire logic [NSRC-1:0] src_flag_clr,
	// core side
	output logic [NSRC-1:0] src_flag_q,
	output logic [NSRC-1:0] src_req
);
	// ----------------------------------------------------------------
	// sticky flags: set beats clear so no event is lost
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			src_flag_q <= '0;
		end else begin
			src_flag_q <= (src_flag_q & ~src_flag_clr) | (src_event & src_enable);
		end
	end

	// level request, held off only by the global mask further up
	assign src_req = src_flag_q & src_enable;

	AST_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!resetn)
		(src_event & src_enable) != '0 |=> (src_flag_q & $past(src_event & src_enable))
		== $past(src_event & src_enable))
		else $error("enabled event did not set its flag");
	AST_FLAG_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
		(src_flag_q & ~src_flag_clr) != '0 |=> (src_flag_q & $past(src_flag_q & ~src_flag_clr))
		== $past(src_flag_q & ~src_flag_clr))
		else $error("flag dropped without a clear");
endmodule
`default_nettype wire

// >>> test/cie_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cie_mem_model (
	// clock and request
	input wire logic sys_clk,
	input wire logic mem_req_q,
	input wire logic mem_we_q,
	input wire logic [15:0] mem_addr_q,
	input wire logic [7:0] mem_wdata_q,
	input wire logic [1:0] dly,
	// answer
	output logic mem_ack,
	output logic [7:0] mem_rdata
);
	// ----------------------------------------------------------------
	// memory: writes kept, reads made from the address
	// ----------------------------------------------------------------
	logic [7:0] wmem [0:65535];
	logic [1:0] cnt;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 8'h00;
		cnt = 2'h0;
	end
	// read data toggles outside the ack so a stale byte cannot pass
	always @(posedge sys_clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req_q && !mem_ack) begin
			if (cnt >= dly) begin
				mem_ack <= 1'b1;
				cnt <= 2'h0;
				if (mem_we_q)
					wmem[mem_addr_q] <= mem_wdata_q;
				else if (mem_addr_q[15:8] == 8'hff)
					mem_rdata <= mem_addr_q[0] ? mem_addr_q[7:0] : 8'h40;
				else
					mem_rdata <= mem_addr_q[7:0] ^ 8'h3c;
			end else begin
				cnt <= cnt + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> test/cpu_interrupt_entry_test.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_entry_test;
	import cie_pkg::*;
	logic sys_clk, resetn, instr_done, soft_int_exec, dbg_soft_req, mask_set, mask_clr;
	logic cond_restore, global_mask_q, mem_req_q, mem_we_q, mem_ack, queue_valid_q;
	logic entry_busy_q, entry_done_q;
	logic [7:0] src_event, src_enable, src_flag_clr, src_flag_q, cond_stacked;
	logic [7:0] reg_a, reg_x, cond_byte, mem_wdata_q, mem_rdata, queue_byte_q;
	logic [15:0] ret_pc, sp_in, sp_q, mem_addr_q, new_pc_q;
	logic [1:0] dly;
	int fail_count, checked, cycles;
	cie_entry #(.NSRC(8), .SELW(3)) dut (.sys_clk, .resetn, .src_event, .src_enable,
		.src_flag_clr, .src_flag_q, .instr_done, .soft_int_exec, .dbg_soft_req, .mask_set,
		.mask_clr, .cond_restore, .cond_stacked, .global_mask_q, .ret_pc, .reg_a, .reg_x,
		.cond_byte, .sp_in, .sp_q, .mem_req_q, .mem_we_q, .mem_addr_q, .mem_wdata_q,
		.mem_ack, .mem_rdata, .queue_byte_q, .queue_valid_q, .new_pc_q, .entry_busy_q,
		.entry_done_q);
	cie_mem_model mem (.sys_clk, .mem_req_q, .mem_we_q, .mem_addr_q, .mem_wdata_q,
		.dly, .mem_ack, .mem_rdata);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic tick;
		@(negedge sys_clk);
	endtask
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// boundary, then follow the whole entry and judge pushes, vector and fill
	task automatic run_entry(input logic [15:0] vec);
		logic [15:0] tgt;
		int n;
		tgt = {8'h40, vec[7:0] + 8'h01};
		n = 0;
		ret_pc = ret_pc + 16'h0111;
		reg_a = ~reg_a;
		instr_done = 1'b1;
		tick;
		instr_done = 1'b0;
		soft_int_exec = 1'b0;
		for (int i = 0; i < 100; i++) begin
			tick;
			if (queue_valid_q === 1'b1) begin
				check("queue byte", 16'(queue_byte_q), 16'((tgt[7:0] + 8'(n)) ^ 8'h3c));
				n++;
			end
			if (entry_done_q === 1'b1)
				break;
		end
		check("fill count", 16'(n), 16'h0003);
		check("new pc", new_pc_q, tgt + 16'h0003);
		check("mask after entry", 16'(global_mask_q), 16'h0001);
		check("sp", sp_q, sp_in - 16'h0005);
		check("push pcl", 16'(mem.wmem[sp_in]), 16'(ret_pc[7:0]));
		check("push pch", 16'(mem.wmem[sp_in - 16'h0001]), 16'(ret_pc[15:8]));
		check("push x", 16'(mem.wmem[sp_in - 16'h0002]), 16'(reg_x));
		check("push a", 16'(mem.wmem[sp_in - 16'h0003]), 16'(reg_a));
		check("push cond", 16'(mem.wmem[sp_in - 16'h0004]), 16'(cond_byte));
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_flags_mask;
		check("mask at reset", 16'(global_mask_q), 16'h0001);
		src_enable = 8'h24;
		src_event = 8'h26;
		tick;
		src_event = 8'h00;
		tick;
		check("flags", 16'(src_flag_q), 16'h0024);
		instr_done = 1'b1;
		tick;
		instr_done = 1'b0;
		repeat (3) tick;
		check("masked start", 16'(entry_busy_q), 16'h0000);
		mask_clr = 1'b1;
		tick;
		mask_clr = 1'b0;
		repeat (3) tick;
		check("no boundary", 16'(entry_busy_q), 16'h0000);
		run_entry(SRC_VECTOR_TOP - 16'h0004);
	endtask
	task automatic t_nest_restore;
		src_flag_clr = 8'h04;
		mask_clr = 1'b1;
		tick;
		src_flag_clr = 8'h00;
		mask_clr = 1'b0;
		dly = 2'h3;
		run_entry(SRC_VECTOR_TOP - 16'h000a);
		src_flag_clr = 8'h20;
		mask_clr = 1'b1;
		tick;
		check("nest clear", 16'(global_mask_q), 16'h0000);
		src_flag_clr = 8'h00;
		mask_clr = 1'b0;
		cond_stacked = 8'h08;
		cond_restore = 1'b1;
		tick;
		check("restore set", 16'(global_mask_q), 16'h0001);
		cond_stacked = 8'hf7;
		tick;
		cond_restore = 1'b0;
		tick;
		check("restore clear", 16'(global_mask_q), 16'h0000);
	endtask
	task automatic t_swi_dbg;
		mask_set = 1'b1;
		tick;
		mask_set = 1'b0;
		soft_int_exec = 1'b1;
		run_entry(SOFT_VECTOR);
		dly = 2'h0;
		dbg_soft_req = 1'b1;
		tick;
		dbg_soft_req = 1'b0;
		repeat (3) tick;
		check("debug waits", 16'(entry_busy_q), 16'h0000);
		run_entry(SOFT_VECTOR);
		cond_stacked = 8'h00;
		cond_restore = 1'b1;
		tick;
		cond_restore = 1'b0;
		resetn = 1'b0;
		tick;
		check("mask second reset", 16'(global_mask_q), 16'h0001);
		resetn = 1'b1;
		tick;
	endtask
	// ----------------------------------------------------------------
	// clock, watchdog, main sequence
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			give_verdict;
		end
	end
	initial begin
		{instr_done, soft_int_exec, dbg_soft_req, mask_set, mask_clr, cond_restore} = 6'h00;
		{src_event, src_enable, src_flag_clr, cond_stacked} = 32'h0000_0000;
		ret_pc = 16'h1234;
		sp_in = 16'h00f0;
		reg_a = 8'ha5;
		reg_x = 8'h5a;
		cond_byte = 8'h62;
		dly = 2'h0;
		resetn = 1'b0;
		repeat (6) tick;
		resetn = 1'b1;
		tick;
		t_flags_mask;
		t_nest_restore;
		t_swi_dbg;
		give_verdict;
	end
endmodule
`default_nettype wire
